// ==== bmsl_pkg.sv ====
`default_nettype none
package bmsl_pkg;
	localparam int unsigned CLK_MHZ          = 200;
	localparam int unsigned READY_STATES     = 100;
	localparam int unsigned RST_LOW_STATES   = 20;
	localparam int unsigned MODE_SETUP_STATES = 4;
	localparam int unsigned RATE_W           = 20;
	localparam int unsigned ADDR_W           = 24;
	localparam int unsigned FIFO_W           = 8;
	localparam int unsigned FIFO_D           = 16;
	localparam logic [23:0] PROG_BASE        = 24'hFFE080;
	localparam logic [23:0] PROG_LAST        = 24'hFFEFFF;
	localparam logic [23:0] BOOT_RSV_BASE    = 24'hFFFF00;
	localparam logic [23:0] BOOT_RSV_LAST    = 24'hFFFF7F;
	localparam logic [23:0] NORMAL_LIMIT     = 24'h00DFFF;
	localparam logic [7:0]  ADJ_END_BYTE     = 8'h00;
	localparam logic [7:0]  ACK_BYTE         = 8'h55;
	localparam logic [3:0]  FRAME_BITS       = 4'hA;
	localparam logic [3:0]  LOW_BITS         = 4'h9;
	localparam logic [11:0] PROG_BYTES       = 12'hF80;
	localparam logic [7:0]  READY_CNT        = 8'h64;

	typedef enum logic [1:0] {
		BMSL_RUN_USER_ADV  = 2'b00,
		BMSL_RUN_USER_NORM = 2'b01,
		BMSL_RUN_BOOT      = 2'b10,
		BMSL_RUN_OTHER     = 2'b11
	} bmsl_run_e;

	typedef enum logic [3:0] {
		BMSL_ST_IDLE    = 4'b0000,
		BMSL_ST_WAIT    = 4'b0001,
		BMSL_ST_ERASE   = 4'b0010,
		BMSL_ST_IDLEHI  = 4'b0011,
		BMSL_ST_MEASURE = 4'b0100,
		BMSL_ST_SENDADJ = 4'b0101,
		BMSL_ST_WAITACK = 4'b0110,
		BMSL_ST_LOAD    = 4'b0111,
		BMSL_ST_BRANCH  = 4'b1000,
		BMSL_ST_USER    = 4'b1001
	} bmsl_state_e;

	typedef struct packed {
		logic [23:0] addr;
		logic [7:0]  data;
	} bmsl_wr_s;

	typedef struct packed {
		logic mode_pin_high;
		logic mode_pin_low;
		logic boot_sel_pin_c;
		logic boot_sel_pin_b;
		logic boot_sel_pin_a;
	} bmsl_strap_s;
endpackage
`default_nettype wire

// ==== bmsl_fifo.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmsl_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clock,
	input  wire logic         rst_b,
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem_r [D];
	logic [AW-1:0] wp_r;
	logic [AW-1:0] rp_r;
	logic [AW:0]   cnt_r;
	logic          push;
	logic          pop;

	assign in_ready  = (cnt_r != (AW+1)'(D));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem_r[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	always_ff @(posedge clock) begin
		if (push) begin
			mem_r[wp_r] <= in_data;
		end
	end

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wp_r <= wp_r + 1'b1;
			end
			if (pop) begin
				rp_r <= rp_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule
`default_nettype wire

// ==== bmsl_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// (R1) Boot mode only when mode pins read 0 and boot pins read 1 at release.
// (R2) User mode: low mode pin picks advanced or normal; normal limits 56 kbyte.
// (R3) Boot select pins become general ports after mode detection.
// (R4) Host streams zero bytes; device measures low period for bit rate.
// (R5) Link frames are 8 data bits, one stop bit, no parity.
// (R6) After rate adjustment the device sends one zero byte.
// (R7) Host answers the zero byte with one 0x55 byte.
// (R8) Host resets the device if the zero byte arrives corrupted.
// (R9) Host uses 2400, 4800 or 9600 bits per second.
// (R10) Rate adjust covers 2 to 20 MHz depending on host rate.
// (R11) RAM 0xFFFF00 to 0xFFFF7F is reserved for the boot program.
// (R12) Program bytes land in RAM 0xFFE080 to 0xFFEFFF.
// (R13) After transfer, execution branches to the RAM program start.
// (R14) Rx line high at reset end; measuring ready about 100 states later.
// (R15) Boot mode erases all flash if any location is not all ones.
// (R16) Before branch: clear rx/tx enables, keep rate, drive tx pin high.
// (R17) Branch leaves general registers undefined, others untouched.
// (R18) Boot mode ends via reset with new mode pins or watchdog overflow.
// (R19) Mode pins stay constant in boot mode, stable 4 states before release.
// (R20) In reset with mode 1, address ports low, bus controls high.
// (R21) User mode needs mode 2 or 3 (the code also picks user normal in mode 1); no flash reads while writes enabled.
// (R22) No interrupt service while flash program or erase runs.
// (R23) Divisor is the low span count of one zero byte over nine bits.
// (R24) After 0x55, program bytes go to successive RAM addresses.
module bmsl_top (
	input  wire logic                  clock,
	input  wire logic                  rst_b,
	input  wire bmsl_pkg::bmsl_strap_s strap,
	input  wire logic                  watchdog_timer_overflow,
	input  wire logic                  serial_rx_line,
	output logic                       serial_tx_line,
	output logic                       tx_pin_direction,
	output logic                       tx_pin_level,
	output logic                       receive_enable,
	output logic                       transmit_enable,
	output logic [19:0]                rate_setting,
	output bmsl_pkg::bmsl_run_e        run_mode,
	output logic                       boot_pins_free,
	output logic                       normal_region_limit,
	output logic [23:0]                normal_limit_addr,
	output logic                       boot_ram_reserved,
	input  wire logic                  flash_blank,
	output logic                       flash_erase_req,
	input  wire logic                  flash_erase_done,
	input  wire logic                  flash_write_enable,
	input  wire logic                  flash_busy,
	output logic                       flash_read_allow,
	output logic                       irq_allow,
	output logic                       addr_port_low_oe_b,
	output logic                       bus_ctrl_high_oe_b,
	output bmsl_pkg::bmsl_wr_s         ram_wr,
	output logic                       ram_wr_valid,
	input  wire logic                  ram_wr_ready,
	output logic                       branch_go,
	output logic [23:0]                branch_addr,
	output logic                       cpu_regs_undefined
);
	import bmsl_pkg::*;

	bmsl_state_e  st_r;
	logic         rst_q_r;
	logic [7:0]   wait_r;
	logic [19:0]  low_cnt_r;
	logic [19:0]  bit_cnt_r;
	logic [3:0]   bit_idx_r;
	logic [7:0]   sh_r;
	logic         rx_busy_r;
	logic         rx_done;
	logic [7:0]   rx_byte_r;
	logic         rx_prev_r;
	logic         tx_busy_r;
	logic         tx_start;
	logic [9:0]   tx_sh_r;
	logic [19:0]  tx_cnt_r;
	logic [3:0]   tx_idx_r;
	logic [11:0]  load_cnt_r;
	logic [23:0]  load_addr_r;
	logic         fifo_valid;
	logic         fifo_ready;
	logic [7:0]   fifo_data;
	logic         fifo_in_ready;
	logic         boot_sel;

	function automatic logic [19:0] half_of(input logic [19:0] v);
		half_of = {1'b0, v[19:1]};
	endfunction

	// Strap decode; boot pins only matter at reset release, mode pins also during reset. [R1] [R2]
	assign boot_sel = !strap.mode_pin_high && !strap.mode_pin_low
		&& strap.boot_sel_pin_c && strap.boot_sel_pin_b
		&& strap.boot_sel_pin_a;

	// The strap is caught on the first edge after release, never by the
	// reset itself; the pins must already be settled by then. [R19]
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rst_q_r  <= 1'b0;
			run_mode <= BMSL_RUN_OTHER;
		end else begin
			rst_q_r <= 1'b1;
			if (!rst_q_r) begin
				if (boot_sel) begin
					run_mode <= BMSL_RUN_BOOT; // [R1]
				end else if (strap.mode_pin_low) begin
					run_mode <= BMSL_RUN_USER_NORM; // [R2]
				end else if (strap.mode_pin_high) begin
					run_mode <= BMSL_RUN_USER_ADV; // [R2] [R21]
				end else begin
					run_mode <= BMSL_RUN_OTHER;
				end
			end
		end
	end

	assign boot_pins_free      = rst_q_r; // [R3]
	assign normal_region_limit = (run_mode == BMSL_RUN_USER_NORM); // [R2]
	assign normal_limit_addr   = NORMAL_LIMIT;
	assign boot_ram_reserved   = (run_mode == BMSL_RUN_BOOT); // [R11]
	assign flash_read_allow    = !flash_write_enable; // [R21]
	assign irq_allow           = !flash_busy && !flash_erase_req; // [R22]
	// Mode 1 strap during reset drives ports; otherwise they float. [R20]
	assign addr_port_low_oe_b  = !(!rst_b && !strap.mode_pin_high
		&& strap.mode_pin_low);
	assign bus_ctrl_high_oe_b  = addr_port_low_oe_b;
	assign cpu_regs_undefined  = branch_go; // [R17]
	assign branch_addr         = PROG_BASE; // [R13]

	// A watchdog overflow drops the link enables and sends the sequencer to the user state. [R18]
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			st_r            <= BMSL_ST_IDLE;
			wait_r          <= '0;
			low_cnt_r       <= '0;
			rate_setting    <= '0;
			receive_enable  <= 1'b0;
			transmit_enable <= 1'b0;
			flash_erase_req <= 1'b0;
			branch_go       <= 1'b0;
		end else if (watchdog_timer_overflow) begin
			st_r            <= BMSL_ST_USER; // [R18]
			flash_erase_req <= 1'b0;
			receive_enable  <= 1'b0;
			transmit_enable <= 1'b0;
			branch_go       <= 1'b0;
		end else begin
			branch_go <= 1'b0;
			case (st_r)
			BMSL_ST_IDLE: begin
				if (rst_q_r) begin
					st_r <= (run_mode == BMSL_RUN_BOOT) ? BMSL_ST_WAIT
						: BMSL_ST_USER;
				end
			end
			BMSL_ST_WAIT: begin
				wait_r <= wait_r + 8'h01;
				if (wait_r == READY_CNT - 8'h01) begin // [R14]
					flash_erase_req <= !flash_blank; // [R15]
					st_r <= BMSL_ST_ERASE;
				end
			end
			BMSL_ST_ERASE: begin
				if (!flash_erase_req || flash_erase_done) begin
					flash_erase_req <= 1'b0; // [R15]
					st_r <= BMSL_ST_IDLEHI;
				end
			end
			BMSL_ST_IDLEHI: begin
				low_cnt_r <= '0;
				// Only a falling edge starts a measurement, so a low span
				// already under way at entry is never counted short.
				if (rx_prev_r && !serial_rx_line) begin
					st_r <= BMSL_ST_MEASURE; // [R4]
				end
			end
			BMSL_ST_MEASURE: begin
				if (!serial_rx_line) begin
					low_cnt_r <= low_cnt_r + 20'h00001; // [R23]
				end else begin
					// Nine low bit times; the clock range bounds this. [R10]
					rate_setting    <= low_cnt_r / 20'(LOW_BITS); // [R23]
					receive_enable  <= 1'b1;
					transmit_enable <= 1'b1;
					st_r <= BMSL_ST_SENDADJ;
				end
			end
			BMSL_ST_SENDADJ: begin
				if (!tx_busy_r) begin
					st_r <= BMSL_ST_WAITACK; // [R6]
				end
			end
			BMSL_ST_WAITACK: begin
				// Leftover zero bytes are ignored until the ack. [R7]
				if (rx_done && rx_byte_r == ACK_BYTE) begin
					st_r <= BMSL_ST_LOAD;
				end
			end
			BMSL_ST_LOAD: begin
				if (load_cnt_r == PROG_BYTES && !fifo_valid
					&& !ram_wr_valid) begin // [R13]
					st_r <= BMSL_ST_BRANCH;
				end
			end
			BMSL_ST_BRANCH: begin
				receive_enable  <= 1'b0; // [R16]
				transmit_enable <= 1'b0; // [R16]
				branch_go       <= 1'b1; // [R13]
				st_r            <= BMSL_ST_USER;
			end
			BMSL_ST_USER: begin
				st_r <= BMSL_ST_USER;
			end
			default: st_r <= BMSL_ST_IDLE;
			endcase
		end
	end

	// Receiver samples mid bit; framing is 8N1. [R5]
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			rx_busy_r <= 1'b0;
			rx_prev_r <= 1'b1;
			bit_cnt_r <= '0;
			bit_idx_r <= '0;
			sh_r      <= '0;
			rx_byte_r <= '0;
			rx_done   <= 1'b0;
		end else begin
			rx_prev_r <= serial_rx_line;
			rx_done   <= 1'b0;
			if (!receive_enable) begin
				rx_busy_r <= 1'b0;
			end else if (!rx_busy_r) begin
				if (rx_prev_r && !serial_rx_line) begin
					rx_busy_r <= 1'b1;
					bit_cnt_r <= half_of(rate_setting);
					bit_idx_r <= '0;
				end
			end else if (bit_cnt_r != '0) begin
				bit_cnt_r <= bit_cnt_r - 20'h00001;
			end else begin
				bit_cnt_r <= rate_setting;
				bit_idx_r <= bit_idx_r + 4'h1;
				if (bit_idx_r != 4'h0 && bit_idx_r < LOW_BITS) begin
					sh_r <= {serial_rx_line, sh_r[7:1]};
				end
				if (bit_idx_r == LOW_BITS) begin
					rx_busy_r <= 1'b0;
					rx_byte_r <= sh_r;
					rx_done   <= serial_rx_line; // Stop bit must be high.
				end
			end
		end
	end

	assign tx_start = (st_r == BMSL_ST_SENDADJ) && !tx_busy_r
		&& transmit_enable;

	// The tx pin idles high, also after branching. [R6] [R16]
	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			tx_busy_r <= 1'b0;
			tx_sh_r   <= '1;
			tx_cnt_r  <= '0;
			tx_idx_r  <= '0;
		end else if (tx_start) begin
			tx_busy_r <= 1'b1;
			tx_sh_r   <= {1'b1, ADJ_END_BYTE, 1'b0}; // [R6]
			tx_cnt_r  <= rate_setting;
			tx_idx_r  <= '0;
		end else if (tx_busy_r) begin
			if (tx_cnt_r != '0) begin
				tx_cnt_r <= tx_cnt_r - 20'h00001;
			end else begin
				tx_cnt_r <= rate_setting;
				tx_sh_r  <= {1'b1, tx_sh_r[9:1]};
				tx_idx_r <= tx_idx_r + 4'h1;
				if (tx_idx_r == FRAME_BITS - 4'h1) begin
					tx_busy_r <= 1'b0;
				end
			end
		end
	end

	assign serial_tx_line   = tx_sh_r[0];
	assign tx_pin_direction = 1'b1; // [R16]
	assign tx_pin_level     = 1'b1; // [R16]

	// Received program bytes queue here so a slow RAM port cannot drop
	// bytes; overflow only if RAM stalls for more than sixteen byte times.
	bmsl_fifo #(
		.W(FIFO_W),
		.D(FIFO_D)
	) u_fifo (
		.clock     (clock),
		.rst_b     (rst_b),
		.in_valid  (rx_done && st_r == BMSL_ST_LOAD
			&& load_cnt_r != PROG_BYTES),
		.in_ready  (fifo_in_ready),
		.in_data   (rx_byte_r),
		.out_valid (fifo_valid),
		.out_ready (fifo_ready),
		.out_data  (fifo_data)
	);

	assign fifo_ready = !ram_wr_valid || ram_wr_ready;

	always_ff @(posedge clock or negedge rst_b) begin
		if (!rst_b) begin
			load_cnt_r   <= '0;
			load_addr_r  <= PROG_BASE;
			ram_wr       <= '0;
			ram_wr_valid <= 1'b0;
		end else begin
			if (rx_done && st_r == BMSL_ST_LOAD && fifo_in_ready
				&& load_cnt_r != PROG_BYTES) begin
				load_cnt_r <= load_cnt_r + 12'h001;
			end
			if (fifo_ready) begin
				ram_wr_valid <= fifo_valid;
				if (fifo_valid) begin
					ram_wr.addr <= load_addr_r; // [R12] [R24]
					ram_wr.data <= fifo_data;
					load_addr_r <= load_addr_r + 24'h000001; // [R24]
				end
			end
		end
	end
endmodule
`default_nettype wire

// ==== bmsl_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmsl_host #(
	parameter int P = 40
) (
	input  wire logic	clock,
	input  wire logic	serial_tx_line,
	output logic		serial_rx_line
);
	logic [7:0]	rx_q[$];
	logic [7:0]	b;
	// The line rests high, so reset ends with it high.
	initial serial_rx_line = 1'h1;
	// One frame, start bit, eight bits LSB first, one stop bit.
	task automatic send(input logic [7:0] v);
		logic [9:0] f;
		f = {1'h1, v, 1'h0};
		for (int k = 0; k < 10; k++) begin
			serial_rx_line = f[k];
			repeat (P) @(negedge clock);
		end
	endtask
	// Samples at mid-bit on its own rate; a bad stop bit drops the byte.
	always begin
		@(negedge serial_tx_line);
		repeat (P / 2) @(posedge clock);
		for (int i = 0; i < 8; i++) begin
			repeat (P) @(posedge clock);
			b[i] = serial_tx_line;
		end
		repeat (P) @(posedge clock);
		if (serial_tx_line === 1'h1)
			rx_q.push_back(b);
	end
endmodule
`default_nettype wire

// ==== bmsl_top_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmsl_top_assertions (
	input wire logic	clock,
	input wire logic	rst_b,
	input wire logic	flash_write_enable,
	input wire logic	flash_read_allow,
	input wire logic	flash_busy,
	input wire logic	flash_erase_req,
	input wire logic	irq_allow,
	input wire logic	addr_port_low_oe_b,
	input wire logic	bus_ctrl_high_oe_b,
	input wire bmsl_pkg::bmsl_run_e	run_mode,
	input wire logic	boot_ram_reserved,
	input wire logic	normal_region_limit,
	input wire logic [23:0]	normal_limit_addr,
	input wire logic	branch_go,
	input wire logic [23:0]	branch_addr,
	input wire logic	cpu_regs_undefined,
	input wire logic	receive_enable,
	input wire logic	transmit_enable,
	input wire logic	serial_tx_line,
	input wire logic	tx_pin_direction,
	input wire logic	tx_pin_level,
	input wire logic [19:0]	rate_setting,
	input wire bmsl_pkg::bmsl_wr_s	ram_wr,
	input wire logic	ram_wr_valid,
	input wire logic	ram_wr_ready
);
	import bmsl_pkg::*;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	sequence link_quiet;
		!receive_enable && !transmit_enable && serial_tx_line
			&& tx_pin_direction && tx_pin_level;
	endsequence
	sequence jump_ok;
		branch_addr == PROG_BASE && cpu_regs_undefined;
	endsequence
	read_gate_a: assert property (
		flash_read_allow == !flash_write_enable)
		else $error("flash read allowed while writes enabled");
	irq_gate_a: assert property (
		irq_allow == (!flash_busy && !flash_erase_req))
		else $error("interrupts allowed during flash work");
	pins_idle_a: assert property (
		addr_port_low_oe_b && bus_ctrl_high_oe_b)
		else $error("port drivers on outside reset");
	boot_rsv_a: assert property (
		boot_ram_reserved == (run_mode == BMSL_RUN_BOOT))
		else $error("boot area reservation wrong");
	limit_addr_a: assert property (
		normal_region_limit |-> normal_limit_addr == NORMAL_LIMIT)
		else $error("normal mode limit address wrong");
	branch_jump_a: assert property (
		branch_go |-> jump_ok ##1 !branch_go)
		else $error("branch pulse or target wrong");
	branch_quiet_a: assert property (
		branch_go |-> link_quiet)
		else $error("serial channel not quiet at branch");
	branch_drain_a: assert property (
		branch_go |-> !ram_wr_valid)
		else $error("branch taken with a program write pending");
	rate_keep_a: assert property (
		receive_enable && $past(receive_enable)
			|-> $stable(rate_setting))
		else $error("rate setting moved while enabled");
	wr_window_a: assert property (
		ram_wr_valid |-> ram_wr.addr inside {[PROG_BASE:PROG_LAST]})
		else $error("program write outside transfer area");
	wr_hold_a: assert property (
		ram_wr_valid && !ram_wr_ready
			|=> ram_wr_valid && $stable(ram_wr))
		else $error("program write dropped while stalled");
endmodule
bind bmsl_top bmsl_top_assertions chk_u (.clock, .rst_b, .flash_write_enable,
	.flash_read_allow, .flash_busy, .flash_erase_req, .irq_allow,
	.addr_port_low_oe_b, .bus_ctrl_high_oe_b, .run_mode, .boot_ram_reserved,
	.normal_region_limit, .normal_limit_addr, .branch_go, .branch_addr,
	.cpu_regs_undefined, .receive_enable, .transmit_enable, .serial_tx_line,
	.tx_pin_direction, .tx_pin_level, .rate_setting, .ram_wr, .ram_wr_valid,
	.ram_wr_ready);
`default_nettype wire

// ==== bmsl_top_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module bmsl_top_tb;
	import bmsl_pkg::*;
	// A short bit period lets a full program load fit the run budget.
	localparam int P = 2;
	localparam int LIMIT = 95000;
	logic	clock, rst_b, watchdog_timer_overflow, serial_rx_line, serial_tx_line;
	logic	tx_pin_direction, tx_pin_level, receive_enable, transmit_enable;
	logic	boot_pins_free, normal_region_limit, boot_ram_reserved, flash_blank;
	logic	flash_erase_req, flash_erase_done, flash_write_enable, flash_busy;
	logic	flash_read_allow, irq_allow, addr_port_low_oe_b, bus_ctrl_high_oe_b;
	logic	ram_wr_valid, ram_wr_ready, branch_go, cpu_regs_undefined, erase_seen;
	logic [19:0]	rate_setting;
	logic [23:0]	normal_limit_addr, branch_addr;
	logic [7:0]	b;
	logic [7:0]	exp_q[$];
	bmsl_strap_s	strap;
	bmsl_run_e	run_mode;
	bmsl_wr_s	ram_wr;
	int	fail_count, n_checks, cyc, nwr, s, branch_seen;
	bmsl_top dut_u (.clock, .rst_b, .strap, .watchdog_timer_overflow,
		.serial_rx_line, .serial_tx_line, .tx_pin_direction, .tx_pin_level,
		.receive_enable, .transmit_enable, .rate_setting, .run_mode,
		.boot_pins_free, .normal_region_limit, .normal_limit_addr,
		.boot_ram_reserved, .flash_blank, .flash_erase_req, .flash_erase_done,
		.flash_write_enable, .flash_busy, .flash_read_allow, .irq_allow,
		.addr_port_low_oe_b, .bus_ctrl_high_oe_b, .ram_wr, .ram_wr_valid,
		.ram_wr_ready, .branch_go, .branch_addr, .cpu_regs_undefined);
	bmsl_host #(.P(P)) host_u (.clock, .serial_tx_line, .serial_rx_line);
	initial begin
		clock = 1'h0;
		forever #2.5 clock = ~clock;
	end
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_checks++;
		if (g !== e) begin
			fail_count++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic chk_bit(input logic g, input logic e);
		chk({31'h0, g}, {31'h0, e});
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	function automatic bmsl_run_e exp_mode(input int v);
		if (v[3])
			return BMSL_RUN_USER_NORM;
		if (v[4])
			return BMSL_RUN_USER_ADV;
		if (v[2:0] == 3'h7)
			return BMSL_RUN_BOOT;
		return BMSL_RUN_OTHER;
	endfunction
	// Random stalls and flash flags; erase completes a cycle after request.
	always @(negedge clock) begin
		ram_wr_ready <= 1'($urandom());
		flash_write_enable <= 1'($urandom());
		flash_busy <= 1'($urandom());
		flash_erase_done <= flash_erase_req;
	end
	always @(posedge clock) begin
		cyc++;
		if (flash_erase_req === 1'h1)
			erase_seen = 1'h1;
		if (rst_b === 1'h1 && ram_wr_valid === 1'h1 && ram_wr_ready === 1'h1) begin
			chk(ram_wr.addr, PROG_BASE + nwr);
			chk(ram_wr.data, exp_q.size() ? exp_q.pop_front() : 8'hXX);
			nwr++;
		end
		chk_bit(flash_read_allow, !flash_write_enable);
		chk_bit(irq_allow, !flash_busy && !flash_erase_req);
		if (branch_go === 1'h1) begin
			branch_seen++;
			chk(branch_addr, PROG_BASE);
			chk(nwr, PROG_BYTES);
			chk_bit(cpu_regs_undefined, 1'h1);
			chk_bit(receive_enable || transmit_enable, 1'h0);
			chk_bit(serial_tx_line && tx_pin_level, 1'h1);
			chk_bit(tx_pin_direction, 1'h1);
			chk(rate_setting, P - 1);
		end
		if (cyc == LIMIT) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		rst_b = 1'h0;
		strap = 5'h0;
		watchdog_timer_overflow = 1'h0;
		flash_blank = 1'h1;
		flash_erase_done = 1'h0;
		flash_write_enable = 1'h0;
		flash_busy = 1'h0;
		ram_wr_ready = 1'h1;
		erase_seen = 1'h0;
		void'($urandom(32'hCCD8));
		// Each strap change sits inside a full reset, so setup is met.
		for (s = 0; s < 32; s++) begin
			@(negedge clock);
			rst_b = 1'h0;
			strap = s[4:0];
			repeat (20) @(negedge clock);
			chk_bit(addr_port_low_oe_b, s[4:3] != 2'h1);
			chk_bit(bus_ctrl_high_oe_b, s[4:3] != 2'h1);
			rst_b = 1'h1;
			repeat (3) @(negedge clock);
			chk(run_mode, exp_mode(s));
			chk_bit(boot_pins_free, 1'h1);
			chk_bit(normal_region_limit, s[3]);
		end
		$display("test strap_modes done");
		flash_blank = 1'h0;
		erase_seen = 1'h0;
		// A lost adjustment byte makes the host reset and start over.
		for (int t = 0; t < 3 && host_u.rx_q.size() == 0; t++) begin
			rst_b = 1'h0;
			strap = 5'h07;
			repeat (20) @(negedge clock);
			rst_b = 1'h1;
			repeat (4) @(negedge clock);
			for (s = 0; s < 30 && host_u.rx_q.size() == 0; s++)
				host_u.send(8'h00);
		end
		chk(host_u.rx_q.size(), 1);
		chk(host_u.rx_q[0], ADJ_END_BYTE);
		// Each bit lasts rate_setting plus one clocks.
		chk(rate_setting, P - 1);
		chk_bit(receive_enable, 1'h1);
		chk_bit(transmit_enable, 1'h1);
		chk_bit(erase_seen, 1'h1);
		chk_bit(boot_ram_reserved, 1'h1);
		// A stray byte before the answer must not start the load.
		host_u.send(8'hA5);
		host_u.send(ACK_BYTE);
		for (s = 0; s < int'(PROG_BYTES); s++) begin
			b = 8'($urandom());
			exp_q.push_back(b);
			host_u.send(b);
		end
		repeat (40) @(negedge clock);
		chk(nwr, PROG_BYTES);
		chk(branch_seen, 1);
		// A byte past the transfer area is never written.
		host_u.send(8'($urandom()));
		repeat (40) @(negedge clock);
		chk(nwr, PROG_BYTES);
		$display("test boot_load done");
		rst_b = 1'h0;
		repeat (20) @(negedge clock);
		rst_b = 1'h1;
		repeat (50) @(negedge clock);
		watchdog_timer_overflow = 1'h1;
		@(negedge clock);
		watchdog_timer_overflow = 1'h0;
		for (s = 0; s < 12; s++)
			host_u.send(8'h00);
		chk(host_u.rx_q.size(), 1);
		chk_bit(receive_enable, 1'h0);
		$display("test watchdog_exit done");
		finish_test();
	end
endmodule
`default_nettype wire
